// ---- core/asp_packetizer.sv ----
// adc sample frame packetizer: sample fifo stream in, dma stream out
// assumes samples and apb synchronous to pclk; downstream honours tlast
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module asp_packetizer (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic                               pready,
  output logic [31:0]                        prdata,
  output logic                               pslverr,
  input  wire logic                          s_tvalid,
  input  wire logic [asp_pkg::SAMPLE_W-1:0]  s_tdata,
  output logic                               s_tready,
  output logic                               m_tvalid,
  output logic [asp_pkg::SAMPLE_W-1:0]       m_tdata,
  output logic                               m_tlast,
  input  wire logic                          m_tready,
  output logic                               fabric_to_processor_irq
);

  // ========================================================
  // address decode
  function automatic asp_pkg::asp_sel_t dec(input logic [7:0] a);
    case (a)
      asp_pkg::OFF_CTRL:     dec = asp_pkg::ASP_SEL_CTRL;
      asp_pkg::OFF_COALESCE: dec = asp_pkg::ASP_SEL_COALESCE;
      asp_pkg::OFF_STATUS:   dec = asp_pkg::ASP_SEL_STATUS;
      asp_pkg::OFF_MASK:     dec = asp_pkg::ASP_SEL_MASK;
      asp_pkg::OFF_COUNT:    dec = asp_pkg::ASP_SEL_COUNT;
      asp_pkg::OFF_FRAMES:   dec = asp_pkg::ASP_SEL_FRAMES;
      default:               dec = asp_pkg::ASP_SEL_NONE;
    endcase
  endfunction

  // ========================================================
  // state
  logic                              en_r, en_nxt;
  logic [asp_pkg::CNT_W-1:0]         coal_r, coal_nxt;
  logic [asp_pkg::NUM_EVT-1:0]       stat_r, stat_nxt;
  logic [asp_pkg::NUM_EVT-1:0]       mask_r, mask_nxt;
  logic [asp_pkg::CNT_W-1:0]         cnt_r, cnt_nxt;
  logic [31:0]                       frames_r, frames_nxt;
  asp_pkg::asp_beat_t                beat_r, beat_nxt;
  logic                              mval_r, mval_nxt;
  logic                              sready_r, sready_nxt;
  logic                              irq_r, irq_nxt;
  logic                              pready_r, pready_nxt;
  logic                              pslverr_r, pslverr_nxt;
  logic [31:0]                       prdata_r, prdata_nxt;

  logic                              take;
  logic                              sent;
  logic                              wr_go;
  logic [asp_pkg::CNT_W-1:0]         frame_len;
  logic [asp_pkg::CNT_W-1:0]         last_idx;
  logic                              frame_done;
  logic                              frame_start;
  logic [asp_pkg::NUM_EVT-1:0]       evt;
  logic [asp_pkg::NUM_EVT-1:0]       w1c;
  asp_pkg::asp_sel_t                 rsel;
  asp_pkg::asp_sel_t                 wsel;

  // ========================================================
  // stream handshakes
  always_comb begin
    take = s_tvalid && sready_r;                           // [R1]
    sent = mval_r && m_tready;
  end

  // ========================================================
  // apb decode
  always_comb begin
    wr_go = psel && penable && pready_r && pwrite;
    rsel  = dec(paddr);
    wsel  = dec(paddr);
  end

  // ========================================================
  // frame length
  always_comb begin
    // coalesce count is in bytes, two bytes per sample
    frame_len = coal_r >> asp_pkg::SAMPLE_SHIFT;          // [R3]
    if (frame_len == asp_pkg::CNT_ZERO) begin
      frame_len = asp_pkg::CNT_ONE;
    end
    last_idx = frame_len - asp_pkg::CNT_ONE;
  end

  // ========================================================
  // framing next values
  always_comb begin
    beat_nxt   = beat_r;
    mval_nxt   = mval_r;
    cnt_nxt    = cnt_r;
    frames_nxt = frames_r;
    if (sent) begin
      mval_nxt = 1'b0;
      if (beat_r.last) begin
        cnt_nxt    = asp_pkg::CNT_ZERO;                    // [R11]
        frames_nxt = frames_r + asp_pkg::FRAMES_ONE;
      end
    end
    if (take) begin                                        // [R6]
      beat_nxt.data = s_tdata;
      // last flag on the final sample; a shrunk count ends early
      beat_nxt.last = (cnt_r >= last_idx);                 // [R2]
      mval_nxt      = 1'b1;
      if (beat_nxt.last) begin
        cnt_nxt = cnt_r;
      end else begin
        cnt_nxt = cnt_r + asp_pkg::CNT_ONE;
      end
    end
  end

  // ========================================================
  // framing registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r    <= asp_pkg::CNT_ZERO;                       // [R12]
      frames_r <= asp_pkg::WORD_ZERO;
      beat_r   <= '0;
      mval_r   <= 1'b0;                                    // [R12]
    end else begin
      cnt_r    <= cnt_nxt;
      frames_r <= frames_nxt;
      beat_r   <= beat_nxt;
      mval_r   <= mval_nxt;
    end
  end

  // ========================================================
  // frame events
  always_comb begin
    frame_done  = sent && beat_r.last;
    frame_start = take && (cnt_r == asp_pkg::CNT_ZERO);
    evt         = '0;
    evt[asp_pkg::EVT_DONE_BIT]  = frame_done;              // [R5]
    evt[asp_pkg::EVT_START_BIT] = frame_start;
  end

  // ========================================================
  // input slot
  always_comb begin
    // slot free next cycle only if it empties and nothing new lands
    sready_nxt = en_nxt && !mval_nxt;                      // [R11]
  end

  // ========================================================
  // input slot register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sready_r <= 1'b0;
    end else begin
      sready_r <= sready_nxt;
    end
  end

  // ========================================================
  // register file next values
  always_comb begin
    en_nxt   = en_r;
    coal_nxt = coal_r;
    mask_nxt = mask_r;
    w1c      = '0;
    if (wr_go) begin
      case (wsel)
        asp_pkg::ASP_SEL_CTRL:     en_nxt = pwdata[asp_pkg::CTRL_EN_BIT];
        asp_pkg::ASP_SEL_COALESCE: coal_nxt = pwdata[asp_pkg::CNT_W-1:0];
        asp_pkg::ASP_SEL_STATUS:   w1c = pwdata[asp_pkg::NUM_EVT-1:0];
        asp_pkg::ASP_SEL_MASK:     mask_nxt = pwdata[asp_pkg::NUM_EVT-1:0];
        default:                   en_nxt = en_r;
      endcase
    end
  end

  // ========================================================
  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r   <= asp_pkg::CTRL_EN_RST;
      coal_r <= asp_pkg::COALESCE_RST;                     // [R12]
      mask_r <= asp_pkg::MASK_RST;
    end else begin
      en_r   <= en_nxt;
      coal_r <= coal_nxt;
      mask_r <= mask_nxt;
    end
  end

  // ========================================================
  // sticky status, set beats clear
  for (genvar i = 0; i < asp_pkg::NUM_EVT; i++) begin : g_stat
    always_comb begin
      stat_nxt[i] = stat_r[i];
      if (w1c[i]) begin
        stat_nxt[i] = 1'b0;
      end
      if (evt[i]) begin
        stat_nxt[i] = 1'b1;
      end
    end
  end

  // ========================================================
  // status registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // ========================================================
  // interrupt line
  always_comb begin
    irq_nxt = |(stat_nxt & mask_nxt);                      // [R5]
  end

  // ========================================================
  // interrupt register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;                                    // [R5]
    end
  end

  // ========================================================
  // apb answer, zero wait states
  always_comb begin
    pready_nxt  = psel && !penable;
    pslverr_nxt = 1'b0;
    prdata_nxt  = asp_pkg::WORD_ZERO;
    if (psel && !penable) begin
      case (rsel)
        asp_pkg::ASP_SEL_CTRL: begin
          prdata_nxt[asp_pkg::CTRL_EN_BIT] = en_r;
        end
        asp_pkg::ASP_SEL_COALESCE: begin
          prdata_nxt[asp_pkg::CNT_W-1:0] = coal_r;
        end
        asp_pkg::ASP_SEL_STATUS: begin
          prdata_nxt[asp_pkg::NUM_EVT-1:0] = stat_r;
        end
        asp_pkg::ASP_SEL_MASK: begin
          prdata_nxt[asp_pkg::NUM_EVT-1:0] = mask_r;
        end
        asp_pkg::ASP_SEL_COUNT: begin
          prdata_nxt[asp_pkg::CNT_W-1:0] = cnt_r;
        end
        asp_pkg::ASP_SEL_FRAMES: begin
          prdata_nxt = frames_r;
        end
        default: begin
          pslverr_nxt = 1'b1;
        end
      endcase
    end
  end

  // ========================================================
  // apb answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= asp_pkg::WORD_ZERO;
    end else begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  // ========================================================
  // apb outputs
  always_comb begin
    pready  = pready_r;
    pslverr = pslverr_r;
    prdata  = prdata_r;
  end

  // ========================================================
  // stream outputs
  always_comb begin
    s_tready = sready_r;
    m_tvalid = mval_r;                                     // [R4]
    m_tdata  = beat_r.data;
    m_tlast  = beat_r.last;                                // [R2]
  end

  // ========================================================
  // interrupt output
  always_comb begin
    fabric_to_processor_irq = irq_r;                       // [R5]
  end

endmodule

// ---- core/asp_pkg.sv ----
// package for the adc sample frame packetizer
// assumes a single pclk domain, apb register access, 16-bit samples
// ==========================================================
// Behaviour
// (R1) a sample is taken only in a cycle where input valid is high
// (R2) frames of 4096 samples, last flag with the final sample
// (R3) frame length from software coalesce count, default 8192 bytes
// (R4) the dma uses the last flag to close each transfer
// (R5) frame completion raises the fabric-to-processor interrupt line
// (R6) the adc wrapper buffers samples in a fifo read by this block
// (R7) processor sets continuous sampling at 961.54 ksps first
// (R8) processor programs dma destination and length before data flows
// (R9) adc configured: sequencer mode, channel select, then clock divisor
// (R10) dma runs in simple direct-register mode, no scatter-gather
// (R11) hold sample and count while ready low; restart count after last
// (R12) reset clears counter, loads default count, output valid low
package asp_pkg;
  // ========================================================
  // widths
  localparam int SAMPLE_W = 16;
  localparam int CNT_W    = 16;
  localparam int NUM_EVT  = 2;

  // ========================================================
  // register offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_COALESCE = 8'h04;
  localparam logic [7:0] OFF_STATUS   = 8'h08;
  localparam logic [7:0] OFF_MASK     = 8'h0C;
  localparam logic [7:0] OFF_COUNT    = 8'h10;
  localparam logic [7:0] OFF_FRAMES   = 8'h14;

  // ========================================================
  // fields and reset values
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          EVT_DONE_BIT  = 0;
  localparam int          EVT_START_BIT = 1;
  localparam int          SAMPLE_SHIFT  = 1;
  localparam logic [CNT_W-1:0] COALESCE_RST = 16'h2000;
  localparam logic [CNT_W-1:0] FRAME_SAMPLES = 16'h1000;
  localparam logic [CNT_W-1:0] CNT_ZERO     = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE      = 16'h0001;
  localparam logic        CTRL_EN_RST   = 1'b1;
  localparam logic [NUM_EVT-1:0] MASK_RST = 2'h1;
  localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;
  localparam logic [31:0] FRAMES_ONE    = 32'h0000_0001;

  // ========================================================
  // register select codes
  typedef enum logic [2:0] {
    ASP_SEL_CTRL,
    ASP_SEL_COALESCE,
    ASP_SEL_STATUS,
    ASP_SEL_MASK,
    ASP_SEL_COUNT,
    ASP_SEL_FRAMES,
    ASP_SEL_NONE
  } asp_sel_t;

  // one stream beat
  typedef struct packed {
    logic [SAMPLE_W-1:0] data;
    logic                last;
  } asp_beat_t;
endpackage

// ---- tb/adc_sample_frame_packetizer_test.sv ----
// testbench: apb and sample source tasks driving the packetizer
// assumes asp_pkg, checker bind and dma model compiled first
`timescale 1ns/1ps
module adc_sample_frame_packetizer_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic pready, pslverr, s_tready, m_tvalid, m_tlast, m_tready, irq, slv;
  logic [31:0] prdata;
  logic s_tvalid = 0, slow = 0;
  logic [15:0] s_tdata = 16'h0000, m_tdata, last_data, seq = 16'h0000;
  int frame_len, err_total = 0, check_count = 0;
  int lens [3] = '{3, 1, 1};
  logic [31:0] cbs [3] = '{32'h6, 32'h2, 32'h0};
  always #2.5 pclk = !pclk;
  asp_packetizer DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .s_tvalid(s_tvalid), .s_tdata(s_tdata), .s_tready(s_tready),
    .m_tvalid(m_tvalid), .m_tdata(m_tdata), .m_tlast(m_tlast),
    .m_tready(m_tready), .fabric_to_processor_irq(irq));
  asp_dma_model u_dma (.pclk(pclk), .presetn(presetn), .slow(slow),
    .m_tvalid(m_tvalid), .m_tdata(m_tdata), .m_tlast(m_tlast),
    .m_tready(m_tready), .last_data(last_data), .frame_len(frame_len));
  // ========================================================
  // tasks
  task automatic complete_run;
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic send(input int n);
    repeat (n) begin
      @(posedge pclk);
      seq = seq + 16'h0001;
      s_tvalid <= 1;
      s_tdata <= seq;
      do @(posedge pclk); while (s_tready !== 1'b1);
      s_tvalid <= 0;
    end
    do @(negedge pclk); while (m_tvalid !== 1'b0);
  endtask
  // ========================================================
  // tests
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    complete_run;
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    rchk(8'h00, 32'h1);
    rchk(8'h04, 32'h2000);
    rchk(8'h0C, 32'h1);
    rchk(8'h1C, 32'h0);
    chk(slv, 1'b1);
    slow <= 1;
    send(4096);
    chk(frame_len, 4096);
    chk(last_data, seq);
    chk(irq, 1'b1);
    rchk(8'h10, 32'h0);
    rchk(8'h14, 32'h1);
    rchk(8'h08, 32'h3);
    apb(1'b1, 8'h08, 32'h3);
    rchk(8'h08, 32'h0);
    chk(irq, 1'b0);
    apb(1'b1, 8'h0C, 32'h0);
    slow <= 0;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 8'h04, cbs[i]);
      send(2 * lens[i]);
      chk(frame_len, lens[i]);
      chk(last_data, seq);
    end
    rchk(8'h14, 32'h7);
    chk(irq, 1'b0);
    apb(1'b1, 8'h0C, 32'h1);
    rchk(8'h08, 32'h3);
    chk(irq, 1'b1);
    apb(1'b1, 8'h04, 32'h6);
    send(1);
    repeat (20) @(posedge pclk);
    rchk(8'h10, 32'h1);
    complete_run;
  end
endmodule

// ---- tb/asp_dma_model.sv ----
// stream sink standing in for the dma stream slave port
// assumes pclk domain; slow makes ready toggle every cycle
`timescale 1ns/1ps
module asp_dma_model (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         slow,
  input  wire logic                         m_tvalid,
  input  wire logic [asp_pkg::SAMPLE_W-1:0] m_tdata,
  input  wire logic                         m_tlast,
  output logic                              m_tready,
  output logic [asp_pkg::SAMPLE_W-1:0]      last_data,
  output int                                frame_len
);
  int beats;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_tready  <= 1'b0;
      last_data <= 16'h0000;
      beats     <= 0;
      frame_len <= 0;
    end else begin
      m_tready <= slow ? !m_tready : 1'b1;
      if (m_tvalid && m_tready) begin
        last_data <= m_tdata;
        beats     <= m_tlast ? 0 : beats + 1;
        if (m_tlast) frame_len <= beats + 1;
      end
    end
  end
endmodule

// ---- tb/asp_packetizer_chk.sv ----
// assertion checker for the packetizer ports
// assumes one pclk domain, bound to every asp_packetizer
`timescale 1ns/1ps
module asp_chk (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic                         s_tvalid,
  input wire logic [asp_pkg::SAMPLE_W-1:0] s_tdata,
  input wire logic                         s_tready,
  input wire logic                         m_tvalid,
  input wire logic [asp_pkg::SAMPLE_W-1:0] m_tdata,
  input wire logic                         m_tlast,
  input wire logic                         m_tready,
  input wire logic                         fabric_to_processor_irq
);
  // ========================================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_take; $rose(m_tvalid) |-> $past(s_tvalid && s_tready); endproperty
  a_take: assert property (p_take) else $error("beat without sample");
  property p_data; $rose(m_tvalid) |-> m_tdata == $past(s_tdata); endproperty
  a_data: assert property (p_data) else $error("beat data wrong");
  property p_hold;
    m_tvalid && !m_tready |=> m_tvalid && $stable(m_tdata) && $stable(m_tlast);
  endproperty
  a_hold: assert property (p_hold) else $error("beat not held");
  property p_slot; m_tvalid |-> !s_tready; endproperty
  a_slot: assert property (p_slot) else $error("slot overrun");
  property p_rst; $rose(presetn) |-> !m_tvalid && !s_tready; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_irq;
    $rose(fabric_to_processor_irq) |-> $past(m_tvalid && m_tready && m_tlast)
      || $past(s_tvalid && s_tready) || $past(psel && penable && pwrite);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
  property p_rdy; psel && penable |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("apb wait state");
  property p_err; pslverr |-> pready && psel && penable; endproperty
  a_err: assert property (p_err) else $error("stray error");
endmodule

bind asp_packetizer asp_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .s_tvalid(s_tvalid), .s_tdata(s_tdata),
  .s_tready(s_tready), .m_tvalid(m_tvalid), .m_tdata(m_tdata),
  .m_tlast(m_tlast), .m_tready(m_tready),
  .fabric_to_processor_irq(fabric_to_processor_irq));
